// >>> rtl/ecc_bank_pkg.sv
// Package: register map, field layout and carrier types of the cache ECC error banks
`default_nettype none
package ecc_bank_pkg;
  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFS_IBANK0 = 4'h0;
  localparam logic [3:0] OFS_IBANK1 = 4'h4;
  localparam logic [3:0] OFS_DBANK0 = 4'h8;
  localparam logic [3:0] OFS_DBANK1 = 4'hC;
  localparam logic [31:0] BANK_RESET = 32'h0000_0000;
  // Writable bits: user 31:30, class 17, ram 16, location 15:2, lock 1, valid 0
  localparam logic [31:0] BANK_WMASK = 32'hC003_FFFF;
  localparam int USER_LSB = 30;
  localparam int CLASS_BIT = 17;
  localparam int RAM_BIT = 16;
  localparam int LOC_LSB = 2;
  localparam int LOCK_BIT = 1;
  localparam int VALID_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // One error report from the cache lookup path
  typedef struct packed {
    logic        valid;
    logic        multi_bit;
    logic        data_ram;
    logic [13:0] location;
  } err_report_t;
  // One software write aimed at a bank
  typedef struct packed {
    logic        en;
    logic [31:0] data;
    logic [3:0]  strb;
  } bank_write_t;
endpackage
`default_nettype wire

// >>> rtl/ecc_bank_pair.sv
// Two error banks of one cache with allocation on a detected error
`default_nettype none
module ecc_bank_pair
(
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire ecc_bank_pkg::err_report_t  report,
  input  wire ecc_bank_pkg::bank_write_t  wr0,
  input  wire ecc_bank_pkg::bank_write_t  wr1,
  output logic [31:0]                     bank0,
  output logic [31:0]                     bank1,
  output logic                            dropped
);
  typedef struct packed {
    logic [31:0] b0;
    logic [31:0] b1;
    logic        drop;
  } pair_state_t;

  pair_state_t s_q;
  pair_state_t s_d;
  logic        free0;
  logic        free1;
  logic [31:0] rec;

  // Byte-lane merge of a software write, reserved bits kept at zero
  function automatic logic [31:0] merge(input logic [31:0]               old,
                                        input ecc_bank_pkg::bank_write_t w);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (w.strb[i])
      begin
        m[i*8 +: 8] = w.data[i*8 +: 8];
      end
    end
    return m & ecc_bank_pkg::BANK_WMASK;
  endfunction

  // New record: user field 00, reserved zero, lock clear, valid set
  always_comb
  begin
    rec = ecc_bank_pkg::BANK_RESET;
    rec[ecc_bank_pkg::CLASS_BIT] = report.multi_bit;
    rec[ecc_bank_pkg::RAM_BIT] = report.data_ram;
    rec[ecc_bank_pkg::LOC_LSB +: 14] = report.location;
    rec[ecc_bank_pkg::VALID_BIT] = 1'b1;
  end

  // Allocation prefers an invalid unlocked bank, then any unlocked one
  always_comb
  begin
    free0 = !s_q.b0[ecc_bank_pkg::LOCK_BIT];
    free1 = !s_q.b1[ecc_bank_pkg::LOCK_BIT];
    s_d = s_q;
    s_d.drop = 1'b0;
    if (wr0.en)
    begin
      s_d.b0 = merge(s_q.b0, wr0);
    end
    if (wr1.en)
    begin
      s_d.b1 = merge(s_q.b1, wr1);
    end
    // Hardware capture wins over a same-cycle software write so no error is lost
    if (report.valid)
    begin
      if (free0 && !s_q.b0[ecc_bank_pkg::VALID_BIT])
      begin
        s_d.b0 = rec;
      end
      else if (free1 && !s_q.b1[ecc_bank_pkg::VALID_BIT])
      begin
        s_d.b1 = rec;
      end
      else if (free0)
      begin
        s_d.b0 = rec;
      end
      else if (free1)
      begin
        s_d.b1 = rec;
      end
      else
      begin
        s_d.drop = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bank0 = s_q.b0;
  assign bank1 = s_q.b1;
  assign dropped = s_q.drop;

  a_locked_kept: assert property (@(posedge mclk) disable iff (rst)
    s_q.b0[ecc_bank_pkg::LOCK_BIT] && !wr0.en |=> s_q.b0 == $past(s_q.b0))
    else $error("locked bank 0 changed");
  a_alloc_valid: assert property (@(posedge mclk) disable iff (rst)
    report.valid && (free0 || free1) |=> bank0[0] || bank1[0])
    else $error("allocation left no valid bank");
  a_user_clear: assert property (@(posedge mclk) disable iff (rst)
    report.valid && free0 && !s_q.b0[0]
    |=> s_q.b0[31:30] == 2'h0 && s_q.b0[29:18] == 12'h000)
    else $error("user field not cleared on allocation");
  a_class_copy: assert property (@(posedge mclk) disable iff (rst)
    report.valid && free0 && !s_q.b0[0] |=> s_q.b0[17] == $past(report.multi_bit))
    else $error("error class not recorded");
  c_drop: cover property (@(posedge mclk) disable iff (rst) s_q.drop);
endmodule
`default_nettype wire

// >>> rtl/axil_slave_port.sv
// AXI4-Lite slave handshake: one write and one read outstanding, register access strobes
`default_nettype none
module axil_slave_port
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_go,
  output logic [3:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic             wr_priv,
  output logic [3:0]       rd_addr,
  output logic             rd_priv,
  output logic             rd_go,
  input  wire logic [31:0] rd_val,
  input  wire logic        rd_err
);
  typedef struct packed {
    logic        aw_f;
    logic [3:0]  aw_a;
    logic        aw_p;
    logic        w_f;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        b_v;
    logic [1:0]  b_r;
    logic        r_v;
    logic [31:0] r_d;
    logic [1:0]  r_r;
  } port_state_t;

  port_state_t s_q;
  port_state_t s_d;

  assign awready = !s_q.aw_f && !s_q.b_v;
  assign wready  = !s_q.w_f && !s_q.b_v;
  assign arready = !s_q.r_v;
  assign wr_go   = s_q.aw_f && s_q.w_f && !s_q.b_v;
  assign wr_addr = s_q.aw_a;
  assign wr_data = s_q.w_d;
  assign wr_strb = s_q.w_s;
  assign wr_priv = s_q.aw_p;
  assign rd_go   = arvalid && arready;
  assign rd_addr = araddr;
  assign rd_priv = arprot[0];

  // Capture address and data in either order, answer once both are held
  always_comb
  begin
    s_d = s_q;
    if (awvalid && awready)
    begin
      s_d.aw_f = 1'b1;
      s_d.aw_a = awaddr;
      s_d.aw_p = awprot[0];
    end
    if (wvalid && wready)
    begin
      s_d.w_f = 1'b1;
      s_d.w_d = wdata;
      s_d.w_s = wstrb;
    end
    if (wr_go)
    begin
      s_d.aw_f = 1'b0;
      s_d.w_f = 1'b0;
      s_d.b_v = 1'b1;
      s_d.b_r = awp_resp(s_q.aw_p);
    end
    if (s_q.b_v && bready)
    begin
      s_d.b_v = 1'b0;
    end
    if (rd_go)
    begin
      s_d.r_v = 1'b1;
      s_d.r_d = rd_val;
      s_d.r_r = rd_err ? ecc_bank_pkg::RESP_SLVERR : ecc_bank_pkg::RESP_OKAY;
    end
    else if (s_q.r_v && rready)
    begin
      s_d.r_v = 1'b0;
    end
  end

  function automatic logic [1:0] awp_resp(input logic p);
    return p ? ecc_bank_pkg::RESP_OKAY : ecc_bank_pkg::RESP_SLVERR;
  endfunction

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bvalid = s_q.b_v;
  assign bresp  = s_q.b_r;
  assign rvalid = s_q.r_v;
  assign rdata  = s_q.r_d;
  assign rresp  = s_q.r_r;

  a_bresp_hold: assert property (@(posedge mclk) disable iff (rst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  c_write: cover property (@(posedge mclk) disable iff (rst) bvalid && bready);
  c_read: cover property (@(posedge mclk) disable iff (rst) rvalid && rready);
endmodule
`default_nettype wire

// >>> rtl/cache_ecc_error_bank.sv
// Top: cache ECC error banks for instruction and data cache behind AXI4-Lite
`default_nettype none
module cache_ecc_error_bank
#(
  parameter bit ECC_PRESENT = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ierr_valid,
  input  wire logic        ierr_multi_bit,
  input  wire logic        ierr_data_ram,
  input  wire logic        ierr_way,
  input  wire logic [9:0]  ierr_index,
  input  wire logic [1:0]  ierr_dword,
  input  wire logic        derr_valid,
  input  wire logic        derr_multi_bit,
  input  wire logic        derr_data_ram,
  input  wire logic [1:0]  derr_way,
  input  wire logic [8:0]  derr_index,
  input  wire logic [2:0]  derr_word,
  output logic             ierr_dropped,
  output logic             derr_dropped
);
  // ---------------------------------------------------------------------------
  // Bus side
  // ---------------------------------------------------------------------------
  logic        wr_go;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_priv;
  logic [3:0]  rd_addr;
  logic        rd_priv;
  logic        rd_go;
  logic [31:0] rd_val;
  logic        rd_err;
  logic        wr_ok;
  logic [31:0] ib0;
  logic [31:0] ib1;
  logic [31:0] db0;
  logic [31:0] db1;
  ecc_bank_pkg::err_report_t irep;
  ecc_bank_pkg::err_report_t drep;
  ecc_bank_pkg::bank_write_t wi0;
  ecc_bank_pkg::bank_write_t wi1;
  ecc_bank_pkg::bank_write_t wd0;
  ecc_bank_pkg::bank_write_t wd1;

  axil_slave_port u_port
  (
    .mclk    (mclk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awprot  (awprot),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arprot  (arprot),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_priv (wr_priv),
    .rd_addr (rd_addr),
    .rd_priv (rd_priv),
    .rd_go   (rd_go),
    .rd_val  (rd_val),
    .rd_err  (rd_err)
  );

  // Unprivileged writes are discarded with SLVERR; absent-option privileged writes are discarded but answered OKAY
  assign wr_ok = wr_go && wr_priv && ECC_PRESENT;

  // Write decode into per-bank strobes
  always_comb
  begin
    wi0 = '{en: wr_ok && wr_addr == ecc_bank_pkg::OFS_IBANK0, data: wr_data, strb: wr_strb};
    wi1 = '{en: wr_ok && wr_addr == ecc_bank_pkg::OFS_IBANK1, data: wr_data, strb: wr_strb};
    wd0 = '{en: wr_ok && wr_addr == ecc_bank_pkg::OFS_DBANK0, data: wr_data, strb: wr_strb};
    wd1 = '{en: wr_ok && wr_addr == ecc_bank_pkg::OFS_DBANK1, data: wr_data, strb: wr_strb};
  end

  // Read mux; unprivileged reads see zero with SLVERR
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (!rd_priv || !ECC_PRESENT)
    begin
      rd_err = 1'b1;
    end
    else
    begin
      unique case (rd_addr)
        ecc_bank_pkg::OFS_IBANK0: rd_val = ib0;
        ecc_bank_pkg::OFS_IBANK1: rd_val = ib1;
        ecc_bank_pkg::OFS_DBANK0: rd_val = db0;
        ecc_bank_pkg::OFS_DBANK1: rd_val = db1;
        default:                  rd_err = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Error reports: location packing per cache geometry
  // ---------------------------------------------------------------------------
  always_comb
  begin
    irep.valid = ierr_valid && ECC_PRESENT;
    irep.multi_bit = ierr_multi_bit;
    irep.data_ram = ierr_data_ram;
    irep.location = {1'b0, ierr_way, ierr_index, ierr_dword};
    drep.valid = derr_valid && ECC_PRESENT;
    drep.multi_bit = derr_multi_bit;
    drep.data_ram = derr_data_ram;
    drep.location = {derr_way, derr_index, derr_word};
  end

  ecc_bank_pair u_ibanks
  (
    .mclk    (mclk),
    .rst     (rst),
    .report  (irep),
    .wr0     (wi0),
    .wr1     (wi1),
    .bank0   (ib0),
    .bank1   (ib1),
    .dropped (ierr_dropped)
  );

  ecc_bank_pair u_dbanks
  (
    .mclk    (mclk),
    .rst     (rst),
    .report  (drep),
    .wr0     (wd0),
    .wr1     (wd1),
    .bank0   (db0),
    .bank1   (db1),
    .dropped (derr_dropped)
  );

  a_unpriv_read: assert property (@(posedge mclk) disable iff (rst)
    rd_go && !arprot[0] |=> rvalid && rdata == 32'h0000_0000 && rresp == 2'h2)
    else $error("unprivileged read leaked data");
  // A capture in the same cycle may legally change a bank, so it is left out
  a_unpriv_write: assert property (@(posedge mclk) disable iff (rst)
    wr_go && !wr_priv && !ierr_valid && !derr_valid |=> $stable(ib0) && $stable(db0))
    else $error("unprivileged write changed a bank");
  // Without the option nothing is captured, so the packing checks only apply with it
  a_dloc_pack: assert property (@(posedge mclk) disable iff (rst)
    ECC_PRESENT && derr_valid && !db0[1] && !db0[0] && !wr_go
    |=> db0[15:2] == $past({derr_way, derr_index, derr_word}))
    else $error("data location packed wrongly");
  a_iloc_pack: assert property (@(posedge mclk) disable iff (rst)
    ECC_PRESENT && ierr_valid && !ib0[1] && !ib0[0] && !wr_go
    |=> ib0[14:2] == $past({ierr_way, ierr_index, ierr_dword})
        && ib0[16] == $past(ierr_data_ram))
    else $error("instruction location packed wrongly");
  c_icap: cover property (@(posedge mclk) disable iff (rst) ierr_valid && !ib0[1]);
  c_dcap: cover property (@(posedge mclk) disable iff (rst) derr_valid && db1[1] && !db0[1]);
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the cache ECC error banks over AXI4-Lite
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid, idrop, ddrop;
  logic [1:0]  bresp, rresp, a_rresp;
  logic [31:0] rdata, a_rdata;
  logic        iv = 1'b0, imb = 1'b0, idr = 1'b0, iway = 1'b0;
  logic [9:0]  iidx = 10'h000;
  logic [1:0]  idw = 2'h0, dway = 2'h0;
  logic        dv = 1'b0, dmb = 1'b0, ddr = 1'b0;
  logic [8:0]  didx = 9'h000;
  logic [2:0]  dwd = 3'h0;
  int          err_count = 0, check_count = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [1:0]  a_rs;
  logic [31:0] a_rd;
  int          drops;

  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // Devices: one built with ECC, one without, sharing the bus inputs
  // ---------------------------------------------------------------------------
  cache_ecc_error_bank uut (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ierr_valid(iv), .ierr_multi_bit(imb), .ierr_data_ram(idr),
    .ierr_way(iway), .ierr_index(iidx), .ierr_dword(idw), .derr_valid(dv),
    .derr_multi_bit(dmb), .derr_data_ram(ddr), .derr_way(dway), .derr_index(didx),
    .derr_word(dwd), .ierr_dropped(idrop), .derr_dropped(ddrop));
  // Same handshake logic, so its read answer lines up with the main device
  cache_ecc_error_bank #(.ECC_PRESENT(1'b0)) uut_absent (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(), .rdata(a_rdata), .rresp(a_rresp), .rvalid(),
    .rready(rready), .ierr_valid(iv), .ierr_multi_bit(imb), .ierr_data_ram(idr),
    .ierr_way(iway), .ierr_index(iidx), .ierr_dword(idw), .derr_valid(dv),
    .derr_multi_bit(dmb), .derr_data_ram(ddr), .derr_way(dway), .derr_index(didx),
    .derr_word(dwd), .ierr_dropped(), .derr_dropped());

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ready is sampled at the falling edge: it only moves on rising edges
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [2:0] p,
                           output logic [1:0] resp);
    logic ah, wh, bh, done;
    done = 1'b0;
    awaddr <= a;
    awprot <= p;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // One edge passes so the next call never raises bready in the step that lowers it
    @(posedge mclk);
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [2:0] p,
                          output logic [31:0] d, output logic [1:0] resp);
    logic ah, done;
    done = 1'b0;
    araddr <= a;
    arprot <= p;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      ah = arvalid && arready;
      if (rvalid)
      begin
        d = rdata;
        resp = rresp;
        a_rd = a_rdata;
        a_rs = a_rresp;
        done = 1'b1;
      end
      @(posedge mclk);
      if (ah) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    // Same spacing as the write: rready is never lowered and raised in one step
    @(posedge mclk);
  endtask

  // One-cycle error pulse; drops counts dropped pulses seen over the next cycles
  task automatic err_pulse(input bit dc, input logic mb, input logic dr, input logic [1:0] w,
                           input logic [9:0] ix, input logic [2:0] o);
    drops = 0;
    if (dc)
    begin
      dv <= 1'b1;
      dmb <= mb;
      ddr <= dr;
      dway <= w;
      didx <= ix[8:0];
      dwd <= o;
    end
    else
    begin
      iv <= 1'b1;
      imb <= mb;
      idr <= dr;
      iway <= w[0];
      iidx <= ix;
      idw <= o[1:0];
    end
    @(posedge mclk);
    iv <= 1'b0;
    dv <= 1'b0;
    repeat (4)
    begin
      @(negedge mclk);
      if ((dc ? ddrop : idrop) === 1'b1) drops++;
      @(posedge mclk);
    end
  endtask

  // Expected record: class 17, RAM 16, location 15:2, valid 0, user and lock zero
  function automatic logic [31:0] rec(bit dc, logic mb, logic dr, logic [1:0] w,
                                      logic [9:0] ix, logic [2:0] o);
    logic [13:0] loc;
    loc = dc ? {w, ix[8:0], o} : {1'b0, w[0], ix, o[1:0]};
    return {14'h0000, mb, dr, loc, 2'b01};
  endfunction

  // ---------------------------------------------------------------------------
  // Watchdog: the whole sequence needs well under a thousand cycles
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Every bank starts empty
    for (int i = 0; i < 4; i++)
    begin
      axi_read(4'(i * 4), 3'h1, rd, rs);
      check("reset value", rd, 32'h0000_0000);
      check("reset resp", 32'(rs), 32'(ecc_bank_pkg::RESP_OKAY));
    end
    // An offset outside the four banks reads zero with an error response
    axi_read(4'h2, 3'h1, rd, rs);
    check("unmapped data", rd, 32'h0000_0000);
    check("unmapped resp", 32'(rs), 32'(ecc_bank_pkg::RESP_SLVERR));
    // Instruction errors fill bank 0 then the still-invalid bank 1
    err_pulse(1'b0, 1'b0, 1'b0, 2'h1, 10'h2A5, 3'h3);
    axi_read(ecc_bank_pkg::OFS_IBANK0, 3'h1, rd, rs);
    check("ibank0", rd, rec(1'b0, 1'b0, 1'b0, 2'h1, 10'h2A5, 3'h3));
    check("absent resp", 32'(a_rs), 32'(ecc_bank_pkg::RESP_SLVERR));
    check("absent data", a_rd, 32'h0000_0000);
    err_pulse(1'b0, 1'b1, 1'b1, 2'h0, 10'h15A, 3'h0);
    axi_read(ecc_bank_pkg::OFS_IBANK1, 3'h1, rd, rs);
    check("ibank1", rd, rec(1'b0, 1'b1, 1'b1, 2'h0, 10'h15A, 3'h0));
    // Data error with the widest way and word fields
    err_pulse(1'b1, 1'b0, 1'b1, 2'h2, 10'h1A5, 3'h5);
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h1, rd, rs);
    check("dbank0", rd, rec(1'b1, 1'b0, 1'b1, 2'h2, 10'h1A5, 3'h5));
    // Unprivileged access is refused both ways
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h0, rd, rs);
    check("user read data", rd, 32'h0000_0000);
    check("user read resp", 32'(rs), 32'(ecc_bank_pkg::RESP_SLVERR));
    axi_write(ecc_bank_pkg::OFS_DBANK0, 32'h0000_0000, 3'h0, rs);
    check("user write resp", 32'(rs), 32'(ecc_bank_pkg::RESP_SLVERR));
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h1, rd, rs);
    check("dbank0 kept", rd, rec(1'b1, 1'b0, 1'b1, 2'h2, 10'h1A5, 3'h5));
    // Lock both data banks; reserved bits read zero
    axi_write(ecc_bank_pkg::OFS_DBANK0, 32'hFFFF_FFFF, 3'h1, rs);
    check("write resp", 32'(rs), 32'(ecc_bank_pkg::RESP_OKAY));
    axi_write(ecc_bank_pkg::OFS_DBANK1, 32'hC000_0002, 3'h1, rs);
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h1, rd, rs);
    check("reserved bits", rd, 32'hC003_FFFF);
    err_pulse(1'b1, 1'b1, 1'b0, 2'h3, 10'h000, 3'h7);
    check("drop pulses", 32'(drops), 32'h0000_0001);
    axi_read(ecc_bank_pkg::OFS_DBANK1, 3'h1, rd, rs);
    check("locked dbank1", rd, 32'hC000_0002);
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h1, rd, rs);
    check("locked dbank0", rd, 32'hC003_FFFF);
    // Unlock bank 1: allocation clears the user field
    axi_write(ecc_bank_pkg::OFS_DBANK1, 32'hC000_0000, 3'h1, rs);
    err_pulse(1'b1, 1'b1, 1'b0, 2'h3, 10'h000, 3'h7);
    check("no drop", 32'(drops), 32'h0000_0000);
    axi_read(ecc_bank_pkg::OFS_DBANK1, 3'h1, rd, rs);
    check("dbank1 alloc", rd, rec(1'b1, 1'b1, 1'b0, 2'h3, 10'h000, 3'h7));
    // Both instruction banks valid and unlocked: bank 0 is overwritten
    err_pulse(1'b0, 1'b0, 1'b1, 2'h0, 10'h001, 3'h1);
    axi_read(ecc_bank_pkg::OFS_IBANK0, 3'h1, rd, rs);
    check("ibank0 reuse", rd, rec(1'b0, 1'b0, 1'b1, 2'h0, 10'h001, 3'h1));
    check("no idrop", 32'(drops), 32'h0000_0000);
    // Reset in mid-run clears a locked bank together with its user field
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axi_read(ecc_bank_pkg::OFS_DBANK0, 3'h1, rd, rs);
    check("dbank0 after reset", rd, 32'h0000_0000);
    axi_read(ecc_bank_pkg::OFS_IBANK0, 3'h1, rd, rs);
    check("ibank0 after reset", rd, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
